/* File: logic/cgsp_defs.svh */
// Offsets, field positions and reset values for the port.
`ifndef CGSP_DEFS_SVH
`define CGSP_DEFS_SVH
`define CGSP_SLAVE_ADDR_W 8'hD2
`define CGSP_CMD_BYTE_BIT 7
`define CGSP_REG_BYTE0 7'h00
`define CGSP_NUM_REGS 1
`define CGSP_B0_SPREAD 5
`define CGSP_B0_SATA 4
`define CGSP_B0_FSC 2
`define CGSP_B0_FSB 1
`define CGSP_B0_FSA 0
`define CGSP_B0_RW_MASK 8'hE8
`define CGSP_B0_RESET 8'h00
`define CGSP_CPU_100 2'h0
`define CGSP_CPU_83 2'h1
`define CGSP_CPU_133 2'h2
`define CGSP_CPU_167 2'h3
`endif

/* File: logic/cgsp_pkg.sv */
// Types shared by the serial configuration port.
package cgsp_pkg;
    typedef enum logic [2:0] {
        CGSP_IDLE,
        CGSP_RX,
        CGSP_RX_ACK,
        CGSP_TX,
        CGSP_TX_ACK,
        CGSP_IGNORE
    } cgsp_state_e;
    typedef enum logic [1:0] {
        CGSP_PH_ADDR,
        CGSP_PH_CMD,
        CGSP_PH_COUNT,
        CGSP_PH_DATA
    } cgsp_phase_e;
endpackage

/* File: logic/cgsp_port.sv */
// Serial configuration slave with strap latch and spread control byte.
`timescale 1ns/1ps
`include "cgsp_defs.svh"
module cgsp_port
    import cgsp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic power_good_latch_input_i,
    input wire logic termination_supply_i,
    input wire logic test_mode_i,
    input wire logic freq_select_a_i,
    input wire logic freq_select_b_i,
    input wire logic freq_select_c_i,
    input wire logic sata_or_ref_select_i,
    output logic straps_latched_o,
    output logic [1:0] cpu_freq_sel_o,
    output logic spread_enable_o,
    output logic powerdown_request_n_o
);

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: nothing but the second stage reads the first.
logic [6:0] pin_s1_q;
logic [6:0] pin_s2_q;
always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        pin_s1_q <= 7'h00;
        pin_s2_q <= 7'h00;
    end else begin
        pin_s1_q <= {test_mode_i, sata_or_ref_select_i, freq_select_c_i,
                     freq_select_b_i, freq_select_a_i, termination_supply_i,
                     power_good_latch_input_i};
        pin_s2_q <= pin_s1_q;
    end
end
logic pg_s;
logic vtt_s;
logic [2:0] fs_s;
logic sata_s;
logic test_s;
assign pg_s = pin_s2_q[0];
assign vtt_s = pin_s2_q[1];
assign fs_s = pin_s2_q[4:2];
assign sata_s = pin_s2_q[5];
assign test_s = pin_s2_q[6];

logic scl_s1_q, scl_s2_q, scl_s3_q;
logic sda_s1_q, sda_s2_q, sda_s3_q;
always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        scl_s1_q <= 1'b1;
        scl_s2_q <= 1'b1;
        scl_s3_q <= 1'b1;
        sda_s1_q <= 1'b1;
        sda_s2_q <= 1'b1;
        sda_s3_q <= 1'b1;
    end else begin
        scl_s1_q <= scl_i;
        scl_s2_q <= scl_s1_q;
        scl_s3_q <= scl_s2_q;
        sda_s1_q <= sda_i;
        sda_s2_q <= sda_s1_q;
        sda_s3_q <= sda_s2_q;
    end
end
logic scl_rise, scl_fall, start_det, stop_det;
assign scl_rise = scl_s2_q & ~scl_s3_q;
assign scl_fall = ~scl_s2_q & scl_s3_q;
assign start_det = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
assign stop_det = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

////////////////////////////////////////////////////////////////////////////
// One-shot strap capture; test mode re-opens the capture.
logic latched_q;
logic [2:0] fs_q;
logic sata_q;
always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        latched_q <= 1'b0;
        fs_q <= 3'h0;
        sata_q <= 1'b0;
    end else if ((!latched_q || test_s) && pg_s && vtt_s) begin
        latched_q <= 1'b1;
        fs_q <= fs_s;
        sata_q <= sata_s;
    end
end
assign straps_latched_o = latched_q;
// Select bit A and the SATA select play no part in the choice.
assign cpu_freq_sel_o = fs_q[2:1];
// Before the latch the pin is power-good, so powerdown reads inactive.
assign powerdown_request_n_o = latched_q ? pg_s : 1'b1;

////////////////////////////////////////////////////////////////////////////
// Byte 0: writable bits are masked, strap bits are latched copies.
logic [7:0] byte0_rw_q;
logic [7:0] byte0_rd;
assign byte0_rd = (byte0_rw_q & `CGSP_B0_RW_MASK) |
                  {3'h0, sata_q, 1'b0, fs_q};
assign spread_enable_o = byte0_rw_q[`CGSP_B0_SPREAD];

////////////////////////////////////////////////////////////////////////////
// Serial slave engine.
cgsp_state_e state_q;
cgsp_phase_e phase_q;
logic [7:0] shift_q;
logic [2:0] bit_q;
logic rd_q;
logic block_q;
logic [6:0] offset_q;
logic first_q;
logic drive_q;
logic out_bit_q;
logic byte_done_q;
logic wr_strobe;
logic [7:0] tx_byte;

// Count first for block reads, then register bytes from the offset up.
assign tx_byte = (block_q && first_q) ? 8'(`CGSP_NUM_REGS) :
                 (offset_q == `CGSP_REG_BYTE0) ? byte0_rd : 8'h00;

always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        state_q <= CGSP_IDLE;
        phase_q <= CGSP_PH_ADDR;
        shift_q <= 8'h00;
        bit_q <= 3'h0;
        rd_q <= 1'b0;
        block_q <= 1'b0;
        offset_q <= 7'h00;
        first_q <= 1'b0;
        drive_q <= 1'b0;
        out_bit_q <= 1'b1;
        byte_done_q <= 1'b0;
    end else if (start_det) begin
        state_q <= CGSP_RX;
        phase_q <= CGSP_PH_ADDR;
        bit_q <= 3'h0;
        drive_q <= 1'b0;
        byte_done_q <= 1'b0;
    end else if (stop_det) begin
        state_q <= CGSP_IDLE;
        drive_q <= 1'b0;
    end else begin
        case (state_q)
            CGSP_IDLE, CGSP_IGNORE: begin
                drive_q <= 1'b0;
            end
            CGSP_RX: begin
                if (scl_rise) begin
                    shift_q <= {shift_q[6:0], sda_s2_q};
                    bit_q <= bit_q + 3'h1;
                    // The fall after a start also sees a zero count, so
                    // the eighth rise is marked on its own.
                    if (bit_q == 3'h7) begin
                        byte_done_q <= 1'b1;
                    end
                end
                if (scl_fall && byte_done_q) begin
                    state_q <= CGSP_RX_ACK;
                    byte_done_q <= 1'b0;
                    case (phase_q)
                        CGSP_PH_ADDR: begin
                            if (shift_q[7:1] == 7'(`CGSP_SLAVE_ADDR_W >> 1)) begin
                                rd_q <= shift_q[0];
                                drive_q <= 1'b1;
                                out_bit_q <= 1'b0;
                                first_q <= 1'b1;
                            end else begin
                                state_q <= CGSP_IGNORE;
                            end
                        end
                        CGSP_PH_CMD: begin
                            block_q <= ~shift_q[`CGSP_CMD_BYTE_BIT];
                            offset_q <= shift_q[6:0];
                            drive_q <= 1'b1;
                            out_bit_q <= 1'b0;
                        end
                        default: begin
                            drive_q <= 1'b1;
                            out_bit_q <= 1'b0;
                        end
                    endcase
                end
            end
            CGSP_RX_ACK: begin
                if (scl_fall) begin
                    drive_q <= 1'b0;
                    bit_q <= 3'h0;
                    if (phase_q == CGSP_PH_ADDR && rd_q) begin
                        state_q <= CGSP_TX;
                        drive_q <= 1'b1;
                        out_bit_q <= tx_byte[7];
                        shift_q <= {tx_byte[6:0], 1'b0};
                    end else begin
                        state_q <= CGSP_RX;
                        case (phase_q)
                            CGSP_PH_ADDR: phase_q <= CGSP_PH_CMD;
                            CGSP_PH_CMD: phase_q <= block_q ?
                                CGSP_PH_COUNT : CGSP_PH_DATA;
                            CGSP_PH_COUNT: phase_q <= CGSP_PH_DATA;
                            default: begin
                                // Block writes step to the next offset.
                                if (block_q) begin
                                    offset_q <= offset_q + 7'h01;
                                end
                            end
                        endcase
                    end
                end
            end
            CGSP_TX: begin
                if (scl_fall) begin
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        state_q <= CGSP_TX_ACK;
                        drive_q <= 1'b0;
                        if (!(block_q && first_q)) begin
                            offset_q <= offset_q + 7'h01;
                        end
                        first_q <= 1'b0;
                    end else begin
                        out_bit_q <= shift_q[7];
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
                end
            end
            CGSP_TX_ACK: begin
                if (scl_rise && sda_s2_q) begin
                    // A NACK ends the read; the host then sends stop.
                    state_q <= CGSP_IGNORE;
                end else if (scl_fall) begin
                    // The next byte goes out only once the ack clock ends.
                    state_q <= CGSP_TX;
                    bit_q <= 3'h0;
                    drive_q <= 1'b1;
                    shift_q <= {tx_byte[6:0], 1'b0};
                    out_bit_q <= tx_byte[7];
                end
            end
            default: state_q <= CGSP_IDLE;
        endcase
    end
end

// Data bytes are committed as their ack begins.
assign wr_strobe = (state_q == CGSP_RX) && scl_fall && byte_done_q &&
                   phase_q == CGSP_PH_DATA && !rd_q;

always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        byte0_rw_q <= `CGSP_B0_RESET;
    end else if (wr_strobe && offset_q == `CGSP_REG_BYTE0) begin
        byte0_rw_q <= shift_q & `CGSP_B0_RW_MASK;
    end
end

// Open-drain: only ever pull low.
assign sda_o = 1'b0;
assign sda_oe_o = drive_q & ~out_bit_q;

endmodule // cgsp_port

/* File: dv/cgsp_host.sv */
// Behavioural SMBus host that drives the port's serial pins.
`timescale 1ns/1ps
module cgsp_host (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task put(input logic b);
        sda_oe_o = !b;
        #40 scl_o = 1'b1;
        #80 scl_o = 1'b0;
        #40;
    endtask
    task get(output logic b);
        sda_oe_o = 1'b0;
        #40 scl_o = 1'b1;
        #40 b = sda_i;
        #40 scl_o = 1'b0;
        #40;
    endtask
    // Also serves as repeated start, since it releases SDA first.
    task start();
        sda_oe_o = 1'b0;
        #40 scl_o = 1'b1;
        #40 sda_oe_o = 1'b1;
        #40 scl_o = 1'b0;
        #40;
    endtask
    task stop();
        sda_oe_o = 1'b1;
        #40 scl_o = 1'b1;
        #40 sda_oe_o = 1'b0;
        #80;
    endtask
    task wr(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put(d[i]);
        get(b);
        ack = !b;
    endtask
    task rd(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(last);
    endtask
endmodule // cgsp_host

/* File: dv/cgsp_port_chk.sv */
// Pin-level assertions for the serial configuration port.
`timescale 1ns/1ps
module cgsp_port_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic power_good_latch_input_i,
    input wire logic test_mode_i,
    input wire logic sda_oe_o,
    input wire logic straps_latched_o,
    input wire logic [1:0] cpu_freq_sel_o,
    input wire logic spread_enable_o,
    input wire logic powerdown_request_n_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_hi; straps_latched_o && power_good_latch_input_i; endsequence
    sequence s_lo; straps_latched_o && !power_good_latch_input_i; endsequence
    property p_rst;
        disable iff (1'b0)
        rst_i |-> !sda_oe_o && !spread_enable_o && powerdown_request_n_o;
    endproperty
    property p_keep; straps_latched_o |=> straps_latched_o; endproperty
    property p_lock;
        (straps_latched_o && !test_mode_i)[*6] |-> $stable(cpu_freq_sel_o);
    endproperty
    property p_pdn; !straps_latched_o |-> powerdown_request_n_o; endproperty
    property p_pdhi; s_hi[*5] |-> powerdown_request_n_o; endproperty
    property p_pdlo; s_lo[*5] |-> !powerdown_request_n_o; endproperty
    property p_quiet;
        (!straps_latched_o && !power_good_latch_input_i)[*4]
            |=> !straps_latched_o;
    endproperty
    property p_hold; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
    a_rst: assert property (p_rst) else $error("bad reset outputs");
    a_keep: assert property (p_keep) else $error("latch dropped");
    a_lock: assert property (p_lock) else $error("select moved");
    a_pdn: assert property (p_pdn) else $error("early powerdown");
    a_pdhi: assert property (p_pdhi) else $error("pd stuck low");
    a_pdlo: assert property (p_pdlo) else $error("pd stuck high");
    a_quiet: assert property (p_quiet) else $error("latch w/o pg");
    a_hold: assert property (p_hold) else $error("sda moved");
endmodule // cgsp_port_chk
bind cgsp_port cgsp_port_chk u_chk (.*);

/* File: dv/cgsp_port_tb.sv */
// Self-checking bench for the serial configuration port.
`timescale 1ns/1ps
module cgsp_port_tb;
    logic clk, rst, scl, sda_oe, sda_o, h_oe, pg, termination_supply, tm;
    logic fa, fb, fc, ss, lat, spr, pdn;
    logic [1:0] cpu;
    logic [3:0] st;
    logic [7:0] d, v;
    wire logic sda = !(h_oe || (sda_oe && !sda_o));
    int err_count = 0, check_count = 0, seed = 26, i;
    cgsp_port uut (.core_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .power_good_latch_input_i(pg),
        .termination_supply_i(termination_supply), .test_mode_i(tm), .freq_select_a_i(fa),
        .freq_select_b_i(fb), .freq_select_c_i(fc),
        .sata_or_ref_select_i(ss), .straps_latched_o(lat),
        .cpu_freq_sel_o(cpu), .spread_enable_o(spr),
        .powerdown_request_n_o(pdn));
    cgsp_host host (.sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
    function logic [7:0] b0(input logic [7:0] w);
        return (w & 8'hE8) | {3'h0, st[3], 1'h0, st[2:0]};
    endfunction
    task chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task final_report();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task wr_op(input logic [7:0] c, input logic [7:0] x);
        logic [3:0] k;
        host.start();
        host.wr(8'hD2, k[0]);
        host.wr(c, k[1]);
        k[2] = 1'b1;
        if (!c[7]) host.wr(8'h01, k[2]);
        host.wr(x, k[3]);
        host.stop();
        chk({4'h0, k}, 8'h0F);
    endtask
    task rd_op(input logic [7:0] c, output logic [7:0] x);
        logic [2:0] k;
        logic [7:0] n;
        host.start();
        host.wr(8'hD2, k[0]);
        host.wr(c, k[1]);
        host.start();
        host.wr(8'hD3, k[2]);
        chk({5'h0, k}, 8'h07);
        if (!c[7]) begin
            host.rd(n, 1'b0);
            chk(n, 8'h01);
        end
        host.rd(x, 1'b1);
        host.stop();
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    initial begin
        #900us;
        err_count++;
        final_report();
    end
    initial begin
        {rst, pg, termination_supply, tm} = 4'h8;
        {ss, fc, fb, fa} = 4'($random(seed));
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1 termination_supply = 1'b1;
        pg = 1'b1;
        st = {ss, fc, fb, fa};
        for (i = 0; i < 50 && lat !== 1'b1; i++) @(posedge clk) #1;
        if (lat !== 1'b1) begin
            err_count++;
            final_report();
        end
        chk({6'h0, cpu}, {6'h0, st[2:1]});
        chk({7'h0, pdn}, 8'h01);
        @(posedge clk) #1 {ss, fc, fb, fa} = ~st;
        pg = 1'b0;
        repeat (8) @(posedge clk);
        chk({6'h0, cpu}, {6'h0, st[2:1]});
        chk({7'h0, pdn}, 8'h00);
        #1 pg = 1'b1;
        rd_op(8'h80, d);
        chk(d, b0(8'h00));
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFF : 8'($random(seed));
            wr_op(8'h80, v);
            chk({7'h0, spr}, {7'h0, v[5]});
            rd_op(8'h80, d);
            chk(d, b0(v));
        end
        wr_op(8'h00, 8'h20);
        chk({7'h0, spr}, 8'h01);
        rd_op(8'h00, d);
        chk(d, b0(8'h20));
        wr_op(8'h85, 8'h00);
        chk({7'h0, spr}, 8'h01);
        rd_op(8'h85, d);
        chk(d, 8'h00);
        host.start();
        host.wr(8'hD4, d[0]);
        host.stop();
        chk({7'h0, d[0]}, 8'h00);
        @(posedge clk) #1 tm = 1'b1;
        repeat (10) @(posedge clk);
        chk({6'h0, cpu}, {6'h0, ~st[2:1]});
        final_report();
    end
endmodule // cgsp_port_tb
